// *** emu_ctrl_checker.sv ***
/* Concurrent checks on the ports of the reset, suspend and port controller.
   Assumes one clock, CORE_CLK, and the synchronous reset SYS_RST. */
`timescale 1ns/1ps
`default_nettype none

module emu_ctrl_checker (
    input wire logic        CORE_CLK,
    input wire logic        SYS_RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        INPUT_ONLY_SWITCH,
    input wire logic        PROGRAM_SOURCE_SWITCH,
    input wire logic [12:0] EPROM_ADDR,
    input wire logic        EPROM_CS_N,
    input wire logic [11:0] PROG_COUNTER,
    input wire logic        CORE_RESET,
    input wire logic        CORE_RUN,
    input wire logic        TIMER_RUN,
    input wire logic        USB_LOW_SPEED,
    input wire logic        PORT_EVENT,
    input wire logic [31:0] PORT_OUT,
    input wire logic [31:0] PORT_OE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    pready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("Ready stood two cycles.");
    setup_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("No ready after setup.");
    reset_state_a: assert property ($fell(SYS_RST) |-> PROG_COUNTER == 12'h000 && CORE_RESET
        && PORT_OE == 32'h0) else $error("Reset state wrong.");
    drive_low_a: assert property (PORT_OUT == 32'h0)
        else $error("Port pin driven high.");
    input_only_a: assert property (INPUT_ONLY_SWITCH [*8] |-> PORT_OE == 32'h0)
        else $error("Pin driven in input-only mode.");
    core_stop_a: assert property (!TIMER_RUN |-> !CORE_RUN)
        else $error("Core runs with timer stopped.");
    low_speed_a: assert property (CORE_RUN |-> USB_LOW_SPEED)
        else $error("Core runs outside low-speed mode.");
    prog_addr_a: assert property (EPROM_ADDR == {1'b0, PROG_COUNTER})
        else $error("Program address leaves lower 4k.");
    rom_select_a: assert property (!PROGRAM_SOURCE_SWITCH [*8] ##0 !CORE_RESET |=> !EPROM_CS_N)
        else $error("EPROM not selected.");

    cover property (PREADY && PSLVERR);
    cover property (!TIMER_RUN && !CORE_RESET);
    cover property (PORT_EVENT);
    cover property ($rose(CORE_RUN));
endmodule

bind emu_reset_suspend_ctrl emu_ctrl_checker i_emu_ctrl_checker (.*);

`default_nettype wire

// *** emu_far_side.sv ***
/* Model of the pins, EPROM and USB lines around the controller.
   Assumes the bench sets external pin sinks and USB activity. */
`timescale 1ns/1ps
`default_nettype none

module emu_far_side (
    input  wire logic        CORE_CLK,
    input  wire logic [31:0] PORT_OE,
    input  wire logic [31:0] PORT_OUT,
    input  wire logic [31:0] ext_low,
    input  wire logic        usb_busy,
    input  wire logic [12:0] EPROM_ADDR,
    input  wire logic        EPROM_CS_N,
    output logic      [31:0] PORT_IN,
    output logic      [7:0]  EPROM_DATA,
    output logic             USB_DP,
    output logic             USB_DM
);
    logic [7:0] last_ff;

    // The weak pull-up holds a pin high only where neither side sinks it.
    assign PORT_IN = (PORT_OE & PORT_OUT) | (~PORT_OE & ~ext_low);
    // A deselected EPROM floats; showing the inverse keeps stale data from matching.
    assign EPROM_DATA = EPROM_CS_N ? ~last_ff : (EPROM_ADDR[7:0] ^ 8'h5A);
    assign USB_DP = usb_busy;
    assign USB_DM = ~usb_busy;

    always_ff @(posedge CORE_CLK)
        last_ff <= EPROM_DATA;
endmodule

`default_nettype wire

// *** emu_pkg.sv ***
/*
  Types of the emulator reset, boot, suspend and port controller.
  Assumes emulator_params.svh is on the include path.
*/
`include "emulator_params.svh"

package emu_pkg;

    typedef enum logic [2:0] {ST_SETTLE, ST_HALT, ST_RUN, ST_STEP, ST_SUSPEND} run_state_t;

    typedef struct packed {
        run_state_t  state;
        logic        por_kind;
        logic        susp_sw;
        logic        resume_run;
        logic [2:0]  settle;
        logic [11:0] pc;
        logic [31:0] ports;
        logic [31:0] polarity;
        logic [31:0] pin_s1;
        logic [31:0] pin_s2;
        logic [31:0] pin_s3;
        logic [31:0] pin_f;
        logic [31:0] pin_prev;
        logic [6:0]  sw_s1;
        logic [6:0]  sw_s2;
        logic [6:0]  sw_s3;
        logic [6:0]  sw_f;
        logic [1:0]  usb_s1;
        logic [1:0]  usb_s2;
        logic [1:0]  usb_s3;
        logic [1:0]  usb_f;
        logic [4:0]  usb_cnt;
        logic [11:0] pram_addr;
        logic [3:0]  cause;
        logic [7:0]  eprom_q;
        logic [7:0]  instr;
        logic [31:0] port_oe;
        logic        port_event;
        logic        core_reset;
        logic        core_run;
        logic        timer_run;
        logic        eprom_cs_n;
        logic        usb_low_speed;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ctrl_state_t;

endpackage

// *** emu_reset_suspend_ctrl.sv ***
/*
  Reset, boot, suspend and general-purpose port control of the emulation board,
  with an APB register slave for software and the debug host.
  Assumes switches, button, USB lines and port pins are asynchronous pins, while the
  EPROM data bus, core handshakes, bus reset, watchdog and interrupt are on CORE_CLK.
*/
`timescale 1ns/1ps
`default_nettype none
`include "emulator_params.svh"

module emu_reset_suspend_ctrl (
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [31:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    input  wire logic        PROGRAM_SOURCE_SWITCH,
    input  wire logic        RUN_ON_RESET_SWITCH,
    input  wire logic        SUSPEND_AFTER_POWERON_SWITCH,
    input  wire logic        INPUT_ONLY_SWITCH,
    input  wire logic        BUS_RESET_ENABLE_SWITCH,
    input  wire logic        WATCHDOG_RESET_ENABLE_SWITCH,
    input  wire logic        RESET_PUSHBUTTON,
    input  wire logic        USB_DP,
    input  wire logic        USB_DM,
    input  wire logic        USB_BUS_RESET,
    input  wire logic        WATCHDOG_EXPIRE,
    input  wire logic        EXT_IRQ,
    input  wire logic        CORE_INSTR_DONE,
    input  wire logic [11:0] CORE_NEXT_PC,
    input  wire logic [7:0]  EPROM_DATA,
    output var  logic [12:0] EPROM_ADDR,
    output var  logic        EPROM_CS_N,
    output var  logic [7:0]  INSTR_DATA,
    output var  logic [11:0] PROG_COUNTER,
    output var  logic        CORE_RESET,
    output var  logic        CORE_RUN,
    output var  logic        TIMER_RUN,
    output var  logic        USB_LOW_SPEED,
    output var  logic        PORT_EVENT,
    input  wire logic [31:0] PORT_IN,
    output var  logic [31:0] PORT_OUT,
    output var  logic [31:0] PORT_OE
);

    localparam emu_pkg::ctrl_state_t RST_VAL = '{
        state:    emu_pkg::ST_SETTLE,
        por_kind: 1'b1,
        ports:    `PORT_RESET_VALUE,
        pin_s1:   `PORT_RESET_VALUE,
        pin_s2:   `PORT_RESET_VALUE,
        pin_s3:   `PORT_RESET_VALUE,
        pin_f:    `PORT_RESET_VALUE,
        pin_prev: `PORT_RESET_VALUE,
        usb_s1:   `USB_IDLE_LEVEL,
        usb_s2:   `USB_IDLE_LEVEL,
        usb_s3:   `USB_IDLE_LEVEL,
        usb_f:    `USB_IDLE_LEVEL,
        cause:    4'h1,
        core_reset: 1'b1,
        eprom_cs_n: 1'b1,
        default:  '0
    };

    localparam logic [4:0] USB_BIT_CNT = 5'(`USB_BIT_CYCLES);
    localparam logic [2:0] SETTLE_LAST = 3'(`SETTLE_CYCLES - 1);

    emu_pkg::ctrl_state_t state_ff;
    emu_pkg::ctrl_state_t nxt_state;

    logic [7:0]  mem_rdata;
    logic        mem_we;
    logic [7:0]  mem_wdata;
    logic        sw_src_ram;
    logic        any_reset;
    logic        button_press;
    logic        usb_active;
    logic        wake;
    logic        acc_wr;
    logic        mapped;
    logic [7:0]  ofs;
    logic [1:0]  sel;
    logic        cmd_run;
    logic        cmd_step;
    logic        cmd_halt;
    logic        sw_suspend;
    logic [31:0] rd_data;

    prog_ram u_prog_ram (
        .clk   (CORE_CLK),
        .we    (mem_we),
        .waddr (state_ff.pram_addr),
        .wdata (mem_wdata),
        .raddr (state_ff.pc),
        .rdata (mem_rdata)
    );

    always_comb
    begin
        nxt_state = state_ff;

        // Three-stage synchronisers; a level is taken once stages two and three agree.
        nxt_state.sw_s1 = {RESET_PUSHBUTTON, WATCHDOG_RESET_ENABLE_SWITCH,
                           BUS_RESET_ENABLE_SWITCH, INPUT_ONLY_SWITCH,
                           SUSPEND_AFTER_POWERON_SWITCH, RUN_ON_RESET_SWITCH,
                           PROGRAM_SOURCE_SWITCH};
        nxt_state.sw_s2 = state_ff.sw_s1;
        nxt_state.sw_s3 = state_ff.sw_s2;
        nxt_state.sw_f = (state_ff.sw_s2 & state_ff.sw_s3)
                       | (state_ff.sw_f & (state_ff.sw_s2 ^ state_ff.sw_s3));
        nxt_state.pin_s1 = PORT_IN;
        nxt_state.pin_s2 = state_ff.pin_s1;
        nxt_state.pin_s3 = state_ff.pin_s2;
        nxt_state.pin_f = (state_ff.pin_s2 & state_ff.pin_s3)
                        | (state_ff.pin_f & (state_ff.pin_s2 ^ state_ff.pin_s3));
        nxt_state.pin_prev = state_ff.pin_f;
        nxt_state.usb_s1 = {USB_DM, USB_DP};
        nxt_state.usb_s2 = state_ff.usb_s1;
        nxt_state.usb_s3 = state_ff.usb_s2;
        nxt_state.usb_f = (state_ff.usb_s2 & state_ff.usb_s3)
                        | (state_ff.usb_f & (state_ff.usb_s2 ^ state_ff.usb_s3));

        // Low-speed idle is D- high, D+ low; activity must last a whole bit time so that
        // a glitch shorter than one 1.5 Mbps symbol cannot wake the board.
        if (state_ff.usb_f == `USB_IDLE_LEVEL)
        begin
            nxt_state.usb_cnt = 5'h00;
        end
        else if (state_ff.usb_cnt != USB_BIT_CNT)
        begin
            nxt_state.usb_cnt = state_ff.usb_cnt + 5'h01;
        end
        usb_active = (state_ff.usb_cnt == USB_BIT_CNT);
        nxt_state.usb_low_speed = 1'b1;

        // A port bit interrupts when its pin moves onto the selected polarity level.
        nxt_state.port_event = |((state_ff.pin_f ^ state_ff.pin_prev)
                               & ~(state_ff.pin_f ^ state_ff.polarity));

        sw_src_ram = state_ff.sw_f[`SW_SOURCE];
        button_press = nxt_state.sw_f[`SW_BUTTON] & ~state_ff.sw_f[`SW_BUTTON];

        // APB slave: the answer is prepared in the setup cycle and registered.
        ofs = PADDR[7:0];
        sel = PADDR[3:2];
        mapped = (PADDR[31:8] == 24'h000000) && (PADDR[1:0] == 2'h0)
              && (ofs <= `OFS_SWITCHES);
        rd_data = 32'h00000000;
        case (ofs)
            `OFS_STATUS_CTRL:
            begin
                rd_data = {26'h0000000, state_ff.sw_f[`SW_SOURCE], state_ff.susp_sw,
                           state_ff.state == emu_pkg::ST_HALT,
                           state_ff.state == emu_pkg::ST_RUN,
                           state_ff.por_kind,
                           state_ff.state == emu_pkg::ST_SUSPEND};
            end
            `OFS_PROG_COUNTER:  rd_data = {20'h00000, state_ff.pc};
            `OFS_RESET_CAUSE:   rd_data = {28'h0000000, state_ff.cause};
            `OFS_PRAM_ADDR:     rd_data = {20'h00000, state_ff.pram_addr};
            `OFS_SWITCHES:      rd_data = {25'h0000000, state_ff.sw_f};
            8'h10, 8'h14, 8'h18, 8'h1C:
            begin
                rd_data = {24'h000000, state_ff.pin_f[sel*8 +: 8]};
            end
            8'h20, 8'h24, 8'h28, 8'h2C:
            begin
                rd_data = {24'h000000, state_ff.polarity[sel*8 +: 8]};
            end
            default:            rd_data = 32'h00000000;
        endcase
        nxt_state.pready = PSEL & ~PENABLE;
        if (PSEL & ~PENABLE)
        begin
            nxt_state.prdata = (mapped && !PWRITE) ? rd_data : 32'h00000000;
            nxt_state.pslverr = ~mapped;
        end
        acc_wr = PSEL & PENABLE & state_ff.pready & PWRITE & mapped;

        cmd_run = acc_wr && (ofs == `OFS_DEBUG_CMD) && PWDATA[`CMD_RUN_BIT];
        cmd_step = acc_wr && (ofs == `OFS_DEBUG_CMD) && PWDATA[`CMD_STEP_BIT];
        cmd_halt = acc_wr && (ofs == `OFS_DEBUG_CMD) && PWDATA[`CMD_HALT_BIT];
        sw_suspend = acc_wr && (ofs == `OFS_STATUS_CTRL) && PWDATA[`CTRL_SUSPEND_BIT];

        if (acc_wr && (ofs[7:4] == 4'h1))
        begin
            nxt_state.ports[sel*8 +: 8] = PWDATA[7:0];
        end
        if (acc_wr && (ofs[7:4] == 4'h2))
        begin
            nxt_state.polarity[sel*8 +: 8] = PWDATA[7:0];
        end
        if (acc_wr && (ofs == `OFS_PRAM_ADDR))
        begin
            nxt_state.pram_addr = PWDATA[11:0];
        end

        // Byte rewrites of program RAM are only honoured in RAM mode; the address
        // steps on so a download can stream bytes without rewriting the pointer.
        mem_we = acc_wr && (ofs == `OFS_PRAM_DATA) && sw_src_ram;
        mem_wdata = PWDATA[7:0];
        if (mem_we)
        begin
            nxt_state.pram_addr = state_ff.pram_addr + 12'h001;
        end

        if (acc_wr && (ofs == `OFS_RESET_CAUSE))
        begin
            nxt_state.cause = state_ff.cause & ~PWDATA[3:0];
        end

        any_reset = button_press
                 | (USB_BUS_RESET & state_ff.sw_f[`SW_BUS_RESET_EN])
                 | (WATCHDOG_EXPIRE & state_ff.sw_f[`SW_WDOG_RESET_EN]);

        wake = usb_active | EXT_IRQ | state_ff.port_event
             | (cmd_run & state_ff.susp_sw);

        case (state_ff.state)
            emu_pkg::ST_SETTLE:
            begin
                // Wait for the switch synchronisers before the boot choice is made.
                nxt_state.settle = state_ff.settle + 3'h1;
                if (state_ff.settle == SETTLE_LAST)
                begin
                    nxt_state.core_reset = 1'b0;
                    nxt_state.resume_run = state_ff.sw_f[`SW_RUN_ON_RESET];
                    if (state_ff.por_kind && state_ff.sw_f[`SW_SUSPEND_POR])
                    begin
                        nxt_state.state = emu_pkg::ST_SUSPEND;
                        nxt_state.susp_sw = 1'b0;
                    end
                    else if (state_ff.sw_f[`SW_RUN_ON_RESET])
                    begin
                        nxt_state.state = emu_pkg::ST_RUN;
                    end
                    else
                    begin
                        nxt_state.state = emu_pkg::ST_HALT;
                    end
                end
            end
            emu_pkg::ST_HALT:
            begin
                if (sw_suspend)
                begin
                    nxt_state.state = emu_pkg::ST_SUSPEND;
                    nxt_state.susp_sw = 1'b1;
                    nxt_state.resume_run = 1'b0;
                end
                else if (cmd_run)
                begin
                    nxt_state.state = emu_pkg::ST_RUN;
                end
                else if (cmd_step)
                begin
                    nxt_state.state = emu_pkg::ST_STEP;
                end
            end
            emu_pkg::ST_RUN, emu_pkg::ST_STEP:
            begin
                if (CORE_INSTR_DONE)
                begin
                    nxt_state.pc = CORE_NEXT_PC;
                end
                if (sw_suspend)
                begin
                    nxt_state.state = emu_pkg::ST_SUSPEND;
                    nxt_state.susp_sw = 1'b1;
                    nxt_state.resume_run = (state_ff.state == emu_pkg::ST_RUN);
                end
                else if (cmd_halt
                      || (CORE_INSTR_DONE && (state_ff.state == emu_pkg::ST_STEP)))
                begin
                    nxt_state.state = emu_pkg::ST_HALT;
                end
            end
            emu_pkg::ST_SUSPEND:
            begin
                if (wake)
                begin
                    nxt_state.susp_sw = 1'b0;
                    nxt_state.state = (state_ff.resume_run || cmd_run) ?
                                      emu_pkg::ST_RUN : emu_pkg::ST_HALT;
                end
            end
            default:
            begin
                nxt_state.state = emu_pkg::ST_HALT;
            end
        endcase

        // Internal resets override everything; a source asserting in the same cycle as a
        // software clear of the cause register still leaves its bit set.
        if (any_reset)
        begin
            nxt_state.state = emu_pkg::ST_SETTLE;
            nxt_state.settle = 3'h0;
            nxt_state.pc = 12'h000;
            nxt_state.ports = `PORT_RESET_VALUE;
            nxt_state.polarity = 32'h00000000;
            nxt_state.pram_addr = 12'h000;
            nxt_state.core_reset = 1'b1;
            nxt_state.susp_sw = 1'b0;
            nxt_state.resume_run = 1'b0;
            nxt_state.por_kind = button_press;
            nxt_state.cause[`CAUSE_BUTTON] = state_ff.cause[`CAUSE_BUTTON] | button_press;
            nxt_state.cause[`CAUSE_USB] = state_ff.cause[`CAUSE_USB]
                | (USB_BUS_RESET & state_ff.sw_f[`SW_BUS_RESET_EN]);
            nxt_state.cause[`CAUSE_WATCHDOG] = state_ff.cause[`CAUSE_WATCHDOG]
                | (WATCHDOG_EXPIRE & state_ff.sw_f[`SW_WDOG_RESET_EN]);
        end

        nxt_state.core_run = (nxt_state.state == emu_pkg::ST_RUN)
                          || (nxt_state.state == emu_pkg::ST_STEP);
        nxt_state.timer_run = (nxt_state.state != emu_pkg::ST_SUSPEND)
                           && (nxt_state.state != emu_pkg::ST_SETTLE);

        // Open-drain drive: a zero in the latch pulls low, a one leaves the board
        // resistor as the only pull-up, which software cannot switch off.
        nxt_state.port_oe = ~nxt_state.ports
                          & {32{~nxt_state.sw_f[`SW_INPUT_ONLY]}};

        // Only the lower 4k of the EPROM is reachable; the top address line stays low.
        nxt_state.eprom_q = EPROM_DATA;
        nxt_state.eprom_cs_n = nxt_state.sw_f[`SW_SOURCE];
        nxt_state.instr = sw_src_ram ? mem_rdata : state_ff.eprom_q;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            state_ff <= RST_VAL;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign PRDATA = state_ff.prdata;
    assign PREADY = state_ff.pready;
    assign PSLVERR = state_ff.pslverr;
    assign EPROM_ADDR = {1'b0, state_ff.pc};
    assign EPROM_CS_N = state_ff.eprom_cs_n;
    assign INSTR_DATA = state_ff.instr;
    assign PROG_COUNTER = state_ff.pc;
    assign CORE_RESET = state_ff.core_reset;
    assign CORE_RUN = state_ff.core_run;
    assign TIMER_RUN = state_ff.timer_run;
    assign USB_LOW_SPEED = state_ff.usb_low_speed;
    assign PORT_EVENT = state_ff.port_event;
    assign PORT_OUT = 32'h00000000;
    assign PORT_OE = state_ff.port_oe;

endmodule

`default_nettype wire

// *** emulator_params.svh ***
/*
  Constants of the emulator reset, boot, suspend and port controller: register
  offsets, field positions, reset values and timing counts.
  Assumes it is included by its bare name by the package and the top module.
*/
// Functional notes
// - Fetch from EPROM or program RAM per switch.
// - Address only lower 4k; RAM same size.
// - After reset run or halt at zero.
// - Power-on suspend until USB activity or interrupt.
// - Program RAM keeps code; host rewrites single bytes.
// - Written zero pulls low, one only weak pull-up.
// - Port reads return pin levels, not latch.
// - Write one before using bit as input.
// - Input-only switch stops all low drive.
// - Power-up or manual reset loads ones.
// - One access moves a whole port.
// - Per-bit interrupt polarity; pull-up always present.
// - Software suspend bit write enters suspend.
// - Suspend stops core and timer.
// - USB activity, reset or interrupt wakes.
// - Run command wakes only software suspend.
// - Reset sources: power-on, button, USB, watchdog.
// - Any reset clears PC and registers.
// - Memories untouched by reset.
// - USB runs low speed only, 1.5 Mbps.
`ifndef EMULATOR_PARAMS_SVH
`define EMULATOR_PARAMS_SVH

`define OFS_STATUS_CTRL   8'h00
`define OFS_DEBUG_CMD     8'h04
`define OFS_PROG_COUNTER  8'h08
`define OFS_RESET_CAUSE   8'h0C
`define OFS_PORT_DATA     8'h10
`define OFS_PORT_POLARITY 8'h20
`define OFS_PRAM_ADDR     8'h30
`define OFS_PRAM_DATA     8'h34
`define OFS_SWITCHES      8'h38

`define CTRL_SUSPEND_BIT  0
`define CMD_RUN_BIT       0
`define CMD_STEP_BIT      1
`define CMD_HALT_BIT      2

`define SW_SOURCE         0
`define SW_RUN_ON_RESET   1
`define SW_SUSPEND_POR    2
`define SW_INPUT_ONLY     3
`define SW_BUS_RESET_EN   4
`define SW_WDOG_RESET_EN  5
`define SW_BUTTON         6

`define CAUSE_POWER_ON    0
`define CAUSE_BUTTON      1
`define CAUSE_USB         2
`define CAUSE_WATCHDOG    3

`define PORT_RESET_VALUE  32'hFFFFFFFF
`define USB_IDLE_LEVEL    2'h2
`define PROG_ADDR_BITS    12
`define PROG_DEPTH        4096

`define CLK_HZ            40000000
`define USB_LS_BPS        1500000
`define USB_BIT_CYCLES    (`CLK_HZ / `USB_LS_BPS)
`define SETTLE_CYCLES     6

`endif

// *** emulator_reset_suspend_port_ctrl_bench.sv ***
/* Self-checking bench of the reset, suspend and port controller.
   Assumes the far-side model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end

module emulator_reset_suspend_port_ctrl_bench;
    logic        CORE_CLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic        PROGRAM_SOURCE_SWITCH = 1'b1, RUN_ON_RESET_SWITCH = 1'b0, EXT_IRQ = 1'b0;
    logic        SUSPEND_AFTER_POWERON_SWITCH = 1'b0, INPUT_ONLY_SWITCH = 1'b0, usb_busy = 1'b0;
    logic        BUS_RESET_ENABLE_SWITCH = 1'b1, WATCHDOG_RESET_ENABLE_SWITCH = 1'b0;
    logic        RESET_PUSHBUTTON = 1'b0, USB_BUS_RESET = 1'b0, WATCHDOG_EXPIRE = 1'b0;
    logic        CORE_INSTR_DONE = 1'b0, PREADY, PSLVERR, EPROM_CS_N, CORE_RESET, err;
    logic        CORE_RUN, TIMER_RUN, USB_LOW_SPEED, PORT_EVENT, USB_DP, USB_DM;
    logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, ext_low = 32'h0, PRDATA, PORT_IN, PORT_OUT;
    logic [31:0] PORT_OE, rd, v;
    logic [11:0] CORE_NEXT_PC = 12'h000, PROG_COUNTER;
    logic [12:0] EPROM_ADDR;
    logic [7:0]  EPROM_DATA, INSTR_DATA, b0;
    int          fail_count = 0, check_count = 0, seed = 84713, saw_event = 0;

    emu_reset_suspend_ctrl i_emu_reset_suspend_ctrl (.*);
    emu_far_side i_emu_far_side (.*);

    always #12.5 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK)
        if (PORT_EVENT === 1'b1)
            saw_event++;

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask

    // One full transfer; the trailing edge keeps back-to-back calls from double-driving.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= {24'h0, a};
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge CORE_CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 16);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1)
        begin
            fail_count++;
            close_out();
        end
        @(posedge CORE_CLK);
    endtask

    // A pin reads low where the latch pulls down or the outside sinks it.
    function automatic logic [7:0] pin_byte(logic [31:0] l, logic [31:0] e, int i);
        return 8'((l & ~e) >> (8 * i));
    endfunction

    initial
    begin
        tick(12);
        SYS_RST <= 1'b0;
        tick(10);
        apb(1'b0, 8'h0C, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd[3:2], 2'b10)
        b0 = 8'($random(seed));
        apb(1'b1, 8'h30, 32'h0);
        apb(1'b1, 8'h34, {24'h0, b0});
        tick(4);
        `CHK(INSTR_DATA, b0)
        PROGRAM_SOURCE_SWITCH <= 1'b0;
        tick(12);
        `CHK(INSTR_DATA, 8'h5A)
        PROGRAM_SOURCE_SWITCH <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 8'h10 + 8'(4 * i), 32'h0);
            `CHK(rd, 32'hFF)
        end
        for (int k = 0; k < 7; k++)
        begin
            v = (k == 0) ? 32'h0 : (k == 6) ? 32'hFFFFFFFF : 32'($random(seed));
            ext_low <= (k == 6) ? 32'h0 : 32'($random(seed));
            for (int i = 0; i < 4; i++)
                apb(1'b1, 8'h10 + 8'(4 * i), {24'h0, v[8*i +: 8]});
            tick(6);
            `CHK(PORT_OE, ~v)
            for (int i = 0; i < 4; i++)
            begin
                apb(1'b0, 8'h10 + 8'(4 * i), 32'h0);
                `CHK(rd[7:0], pin_byte(v, ext_low, i))
            end
            INPUT_ONLY_SWITCH <= (k == 3);
            tick(10);
            if (k == 3)
                `CHK(PORT_OE, 32'h0)
            INPUT_ONLY_SWITCH <= 1'b0;
        end
        ext_low <= 32'h1;
        apb(1'b1, 8'h20, 32'h1);
        tick(8);
        saw_event = 0;
        ext_low <= 32'h0;
        tick(8);
        `CHK(saw_event != 0, 1'b1)
        apb(1'b1, 8'h04, 32'h2);
        tick(3);
        `CHK(CORE_RUN, 1'b1)
        CORE_NEXT_PC <= 12'h010;
        CORE_INSTR_DONE <= 1'b1;
        tick(1);
        CORE_INSTR_DONE <= 1'b0;
        tick(3);
        `CHK({CORE_RUN, PROG_COUNTER}, 13'h0010)
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b1, 8'h04, 32'h4);
        tick(3);
        `CHK(CORE_RUN, 1'b0)
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b1, 8'h00, 32'h1);
        tick(3);
        `CHK({CORE_RUN, TIMER_RUN}, 2'b00)
        apb(1'b1, 8'h04, 32'h1);
        tick(3);
        `CHK(CORE_RUN, 1'b1)
        apb(1'b1, 8'h00, 32'h1);
        tick(2);
        `CHK(CORE_RUN, 1'b0)
        EXT_IRQ <= 1'b1;
        tick(1);
        EXT_IRQ <= 1'b0;
        tick(3);
        `CHK(CORE_RUN, 1'b1)
        SUSPEND_AFTER_POWERON_SWITCH <= 1'b1;
        RUN_ON_RESET_SWITCH <= 1'b1;
        tick(10);
        apb(1'b1, 8'h0C, 32'hF);
        USB_BUS_RESET <= 1'b1;
        tick(1);
        USB_BUS_RESET <= 1'b0;
        tick(12);
        apb(1'b0, 8'h0C, 32'h0);
        `CHK(rd, 32'h4)
        `CHK({CORE_RUN, PROG_COUNTER}, 13'h1000)
        for (int k = 0; k < 2; k++)
        begin
            WATCHDOG_RESET_ENABLE_SWITCH <= (k == 1);
            tick(10);
            WATCHDOG_EXPIRE <= 1'b1;
            tick(1);
            WATCHDOG_EXPIRE <= 1'b0;
            tick(12);
            apb(1'b0, 8'h0C, 32'h0);
            `CHK(rd, (k == 1) ? 32'hC : 32'h4)
        end
        RESET_PUSHBUTTON <= 1'b1;
        tick(10);
        RESET_PUSHBUTTON <= 1'b0;
        tick(12);
        `CHK({CORE_RUN, TIMER_RUN}, 2'b00)
        `CHK(INSTR_DATA, b0)
        apb(1'b1, 8'h04, 32'h1);
        tick(3);
        `CHK(CORE_RUN, 1'b0)
        usb_busy <= 1'b1;
        tick(40);
        usb_busy <= 1'b0;
        tick(4);
        `CHK(CORE_RUN, 1'b1)
        apb(1'b0, 8'h3C, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        `CHK(USB_LOW_SPEED, 1'b1)
        close_out();
    end
endmodule

`default_nettype wire

// *** prog_ram.sv ***
/*
  Program RAM of 4k bytes with one write port and one registered read port.
  Assumes a single clock; contents have no reset and are undefined at power-up.
*/
`timescale 1ns/1ps
`default_nettype none

module prog_ram (
    input  wire logic        clk,
    input  wire logic        we,
    input  wire logic [11:0] waddr,
    input  wire logic [7:0]  wdata,
    input  wire logic [11:0] raddr,
    output var  logic [7:0]  rdata
);

    logic [7:0] mem [0:4095];
    logic [7:0] rdata_ff;

    // No reset on purpose: firmware survives every reset source.
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata_ff <= mem[raddr];
    end

    assign rdata = rdata_ff;

endmodule

`default_nettype wire
